// File: scp_top.sv
// Purpose: two-instance synchronism close-permit supervisor
// Assumes: up to eight measurement sources arrive from upstream logic
// Notes: settings reached over Avalon-MM, one wait state on every access
//
// Summary of operation
// [R1] two identical independent check instances, own outputs
// [R2] permit needs magnitude, angle, frequency all within
// [R3] software must pick two different sources
// [R4] magnitude ok when kV difference below limit
// [R5] angle ok when phasor difference below limit
// [R6] frequency ok when Hz difference below limit
// [R7] selected dead/live combination bypasses, permits close
// [R8] bypass selector: none plus five combinations
// [R9] dead when pu below own dead threshold
// [R10] live when pu above own live threshold
// [R11] both with phase sets: compare A-to-B voltages
// [R12] auxiliary only: compare auxiliary with matching quantity
// [R13] delta phase against wye auxiliary not allowed
// [R14] re-evaluate on update strobe, registered, reset clear
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module scp_top
   import scp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic update_strobe,
   input wire scp_source_t [7:0] sources,
   output logic [SCP_NUM_INST-1:0] close_permit
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      scp_settings_t [SCP_NUM_INST-1:0] cfg;
      scp_result_t [SCP_NUM_INST-1:0] res;
      logic ack;
      logic [31:0] rdata;
   } scp_state_t;

   scp_state_t state_reg;
   scp_state_t state_next;

   scp_result_t [SCP_NUM_INST-1:0] res_now;

   // ----------------------------------------------------------------
   // per-instance datapath
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < SCP_NUM_INST; gi++) begin : g_inst // R1
         scp_compared_t v1;
         scp_compared_t v2;
         scp_select u_select (
            .src_y(sources[state_reg.cfg[gi].first_voltage_source_select]),
            .src_z(sources[state_reg.cfg[gi].second_voltage_source_select]),
            .cmp_y(v1),
            .cmp_z(v2)
         );
         scp_check u_check (
            .cfg(state_reg.cfg[gi]),
            .v1(v1),
            .v2(v2),
            .res(res_now[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return m;
   endfunction : merge

   function automatic logic [31:0] status_word(input scp_result_t r);
      logic [31:0] w;
      w = '0;
      w[SCP_ST_PERMIT] = r.permit;
      w[SCP_ST_SYNC] = r.sync_ok;
      w[SCP_ST_DEAD1] = r.first_is_dead;
      w[SCP_ST_DEAD2] = r.second_is_dead;
      w[SCP_ST_LIVE1] = r.first_is_live;
      w[SCP_ST_LIVE2] = r.second_is_live;
      w[SCP_ST_NOSEL] = r.no_selection;
      return w;
   endfunction : status_word

   logic inst_sel;
   logic [7:0] ofs;
   logic in_range;
   logic [31:0] cur;
   logic [31:0] wv;
   scp_settings_t c;

   always_comb begin
      state_next = state_reg;
      state_next.ack = 1'b0;
      inst_sel = avs_address[6];
      ofs = avs_address & 8'h3F;
      in_range = (avs_address[7] == 1'b0);
      c = state_reg.cfg[inst_sel];
      cur = SCP_UNMAPPED_READ;
      case (ofs)
         SCP_OFS_SRC_SEL: begin
            cur[SCP_SRC1_LSB +: SCP_SRC_W] = c.first_voltage_source_select;
            cur[SCP_SRC2_LSB +: SCP_SRC_W] = c.second_voltage_source_select;
         end
         SCP_OFS_MAX_MAG: cur[15:0] = c.max_magnitude_difference;
         SCP_OFS_MAX_ANG: cur[15:0] = c.max_angle_difference;
         SCP_OFS_MAX_FRQ: cur[15:0] = c.max_frequency_difference;
         SCP_OFS_DEAD_SEL: cur[2:0] = c.dead_live_bypass_select;
         SCP_OFS_DEAD1: cur[15:0] = c.first_dead_threshold;
         SCP_OFS_DEAD2: cur[15:0] = c.second_dead_threshold;
         SCP_OFS_LIVE1: cur[15:0] = c.first_live_threshold;
         SCP_OFS_LIVE2: cur[15:0] = c.second_live_threshold;
         SCP_OFS_STATUS: cur = status_word(state_reg.res[inst_sel]);
         default: cur = SCP_UNMAPPED_READ;
      endcase
      if (!in_range) begin
         cur = SCP_UNMAPPED_READ;
      end
      wv = merge(cur, avs_writedata, avs_byteenable);
      // one wait state: ack completes the access on the following edge
      if ((avs_read || avs_write) && !state_reg.ack) begin
         state_next.ack = 1'b1;
         state_next.rdata = cur;
      end
      // a write lands only at the edge where waitrequest is seen low
      if (avs_write && state_reg.ack) begin
         if (in_range) begin
            case (ofs)
               SCP_OFS_SRC_SEL: begin
                  // equal selections are the software's error; taken as is
                  c.first_voltage_source_select =
                     wv[SCP_SRC1_LSB +: SCP_SRC_W]; // R3
                  c.second_voltage_source_select =
                     wv[SCP_SRC2_LSB +: SCP_SRC_W];
               end
               SCP_OFS_MAX_MAG: c.max_magnitude_difference = wv[15:0];
               SCP_OFS_MAX_ANG: c.max_angle_difference = wv[15:0];
               SCP_OFS_MAX_FRQ: c.max_frequency_difference = wv[15:0];
               SCP_OFS_DEAD_SEL: begin
                  // unknown codes fall back to no bypass
                  c.dead_live_bypass_select = (wv[2:0] > 3'h5) ?
                     SCP_BYP_NONE : scp_bypass_t'(wv[2:0]); // R8
               end
               SCP_OFS_DEAD1: c.first_dead_threshold = wv[15:0];
               SCP_OFS_DEAD2: c.second_dead_threshold = wv[15:0];
               SCP_OFS_LIVE1: c.first_live_threshold = wv[15:0];
               SCP_OFS_LIVE2: c.second_live_threshold = wv[15:0];
               default: c = c;
            endcase
            state_next.cfg[inst_sel] = c;
         end
      end
      // results move only on a measurement update
      if (update_strobe) begin
         state_next.res = res_now; // R14
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
         for (int i = 0; i < SCP_NUM_INST; i++) begin
            state_reg.cfg[i].first_voltage_source_select <= SCP_RST_SRC1;
            state_reg.cfg[i].second_voltage_source_select <= SCP_RST_SRC2;
            state_reg.cfg[i].first_dead_threshold <= SCP_RST_THR;
         end
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_comb begin
      avs_waitrequest = (avs_read | avs_write) & ~state_reg.ack;
      avs_readdata = state_reg.rdata;
      for (int i = 0; i < SCP_NUM_INST; i++) begin
         close_permit[i] = state_reg.res[i].permit; // R14
      end
   end

endmodule : scp_top

// File: scp_pkg.sv
// Purpose: shared constants and types for the close-permit supervisor
// Assumes: fixed-point measurement words from upstream logic
// Notes: magnitudes in kV and pu are unsigned fixed point
package scp_pkg;

   // ----------
   // widths
   // ----------
   localparam int SCP_MAG_W = 16;
   localparam int SCP_ANG_W = 16;
   localparam int SCP_FRQ_W = 16;
   localparam int SCP_SRC_W = 3;
   localparam int SCP_NUM_INST = 2;

   // ----------
   // register map, one aligned word each, per instance block
   // ----------
   localparam logic [7:0] SCP_OFS_SRC_SEL = 8'h00;
   localparam logic [7:0] SCP_OFS_MAX_MAG = 8'h04;
   localparam logic [7:0] SCP_OFS_MAX_ANG = 8'h08;
   localparam logic [7:0] SCP_OFS_MAX_FRQ = 8'h0C;
   localparam logic [7:0] SCP_OFS_DEAD_SEL = 8'h10;
   localparam logic [7:0] SCP_OFS_DEAD1 = 8'h14;
   localparam logic [7:0] SCP_OFS_DEAD2 = 8'h18;
   localparam logic [7:0] SCP_OFS_LIVE1 = 8'h1C;
   localparam logic [7:0] SCP_OFS_LIVE2 = 8'h20;
   localparam logic [7:0] SCP_OFS_STATUS = 8'h24;
   localparam logic [7:0] SCP_INST_STRIDE = 8'h40;
   // field positions in the source select word
   localparam int SCP_SRC1_LSB = 0;
   localparam int SCP_SRC2_LSB = 4;
   // status bits
   localparam int SCP_ST_PERMIT = 0;
   localparam int SCP_ST_SYNC = 1;
   localparam int SCP_ST_DEAD1 = 2;
   localparam int SCP_ST_DEAD2 = 3;
   localparam int SCP_ST_LIVE1 = 4;
   localparam int SCP_ST_LIVE2 = 5;
   localparam int SCP_ST_NOSEL = 6;
   localparam logic [31:0] SCP_UNMAPPED_READ = 32'h0000_0000;

   // ----------
   // reset values
   // ----------
   localparam logic [2:0] SCP_RST_SRC1 = 3'h0;
   localparam logic [2:0] SCP_RST_SRC2 = 3'h1;
   localparam logic [15:0] SCP_RST_THR = 16'h0000;

   // ----------
   // dead/live bypass choices
   // ----------
   typedef enum logic [2:0] {
      SCP_BYP_NONE,
      SCP_BYP_L1_D2,
      SCP_BYP_D1_L2,
      SCP_BYP_D1_OR_D2,
      SCP_BYP_D1_XOR_D2,
      SCP_BYP_D1_AND_D2
   } scp_bypass_t;

   // ----------
   // carriers
   // ----------
   typedef struct packed {
      logic has_phase;
      logic has_aux;
      logic delta;
      logic aux_is_phase_a_ground;
      logic [SCP_MAG_W-1:0] phase_a_to_b_voltage;
      logic [SCP_MAG_W-1:0] phase_a_to_ground_voltage;
      logic [SCP_MAG_W-1:0] aux_voltage;
      logic [SCP_MAG_W-1:0] phase_a_to_b_pu;
      logic [SCP_MAG_W-1:0] phase_a_to_ground_pu;
      logic [SCP_MAG_W-1:0] aux_pu;
      logic [SCP_ANG_W-1:0] phase_a_to_b_angle;
      logic [SCP_ANG_W-1:0] phase_a_to_ground_angle;
      logic [SCP_ANG_W-1:0] aux_angle;
      logic [SCP_FRQ_W-1:0] frequency;
   } scp_source_t;

   typedef struct packed {
      logic [SCP_SRC_W-1:0] first_voltage_source_select;
      logic [SCP_SRC_W-1:0] second_voltage_source_select;
      logic [SCP_MAG_W-1:0] max_magnitude_difference;
      logic [SCP_ANG_W-1:0] max_angle_difference;
      logic [SCP_FRQ_W-1:0] max_frequency_difference;
      scp_bypass_t dead_live_bypass_select;
      logic [SCP_MAG_W-1:0] first_dead_threshold;
      logic [SCP_MAG_W-1:0] second_dead_threshold;
      logic [SCP_MAG_W-1:0] first_live_threshold;
      logic [SCP_MAG_W-1:0] second_live_threshold;
   } scp_settings_t;

   typedef struct packed {
      logic valid;
      logic [SCP_MAG_W-1:0] kv;
      logic [SCP_MAG_W-1:0] pu;
      logic [SCP_ANG_W-1:0] angle;
      logic [SCP_FRQ_W-1:0] frequency;
   } scp_compared_t;

   typedef struct packed {
      logic permit;
      logic sync_ok;
      logic first_is_dead;
      logic second_is_dead;
      logic first_is_live;
      logic second_is_live;
      logic no_selection;
   } scp_result_t;

endpackage : scp_pkg

// File: scp_select.sv
// Purpose: picks the matching voltage channel of two sources
// Assumes: source descriptors are stable between update strobes
// Notes: combinational only
`timescale 1ns/1ps
module scp_select
   import scp_pkg::*;
(
   input wire scp_source_t src_y,
   input wire scp_source_t src_z,
   output scp_compared_t cmp_y,
   output scp_compared_t cmp_z
);

   // ----------------------------------------------------------------
   // channel picking
   // ----------------------------------------------------------------
   function automatic scp_compared_t pick_ab(input scp_source_t s);
      scp_compared_t c;
      c = '0;
      c.valid = 1'b1;
      c.kv = s.phase_a_to_b_voltage;
      c.pu = s.phase_a_to_b_pu;
      c.angle = s.phase_a_to_b_angle;
      c.frequency = s.frequency;
      return c;
   endfunction : pick_ab

   function automatic scp_compared_t pick_match(input scp_source_t s,
                                                input logic use_aux,
                                                input logic as_ag);
      scp_compared_t c;
      c = '0;
      c.valid = 1'b1;
      c.frequency = s.frequency;
      if (use_aux) begin
         c.kv = s.aux_voltage;
         c.pu = s.aux_pu;
         c.angle = s.aux_angle;
      end else if (as_ag) begin
         c.kv = s.phase_a_to_ground_voltage;
         c.pu = s.phase_a_to_ground_pu;
         c.angle = s.phase_a_to_ground_angle;
      end else begin
         c.kv = s.phase_a_to_b_voltage;
         c.pu = s.phase_a_to_b_pu;
         c.angle = s.phase_a_to_b_angle;
      end
      return c;
   endfunction : pick_match

   logic y_aux_only;
   logic z_aux_only;
   logic as_ag;
   logic bad_mix;

   always_comb begin
      y_aux_only = src_y.has_aux & ~src_y.has_phase;
      z_aux_only = src_z.has_aux & ~src_z.has_phase;
      // the programmed auxiliary quantity decides what the other side gives
      as_ag = y_aux_only ? src_y.aux_is_phase_a_ground
                         : src_z.aux_is_phase_a_ground;
      // delta phase set against a wye auxiliary cannot be compared
      bad_mix = (y_aux_only & src_z.has_phase & src_z.delta & as_ag) |
                (z_aux_only & src_y.has_phase & src_y.delta & as_ag);
      if (src_y.has_phase && src_z.has_phase) begin
         cmp_y = pick_ab(src_y); // R11
         cmp_z = pick_ab(src_z); // R11
      end else if ((y_aux_only || z_aux_only) && !bad_mix &&
                   (src_y.has_phase || src_y.has_aux) &&
                   (src_z.has_phase || src_z.has_aux)) begin
         cmp_y = pick_match(src_y, y_aux_only, as_ag); // R12
         cmp_z = pick_match(src_z, z_aux_only, as_ag); // R12
      end else begin
         cmp_y = '0; // R13
         cmp_z = '0;
      end
   end

endmodule : scp_select

// File: scp_check.sv
// Purpose: per-instance dead/live and difference checks
// Assumes: angles are wrapped signed differences in two's complement
// Notes: combinational only; the top registers the result
`timescale 1ns/1ps
module scp_check
   import scp_pkg::*;
(
   input wire scp_settings_t cfg,
   input wire scp_compared_t v1,
   input wire scp_compared_t v2,
   output scp_result_t res
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] abs_diff(input logic [15:0] a,
                                            input logic [15:0] b);
      return (a > b) ? 16'(a - b) : 16'(b - a);
   endfunction : abs_diff

   logic [SCP_ANG_W-1:0] ang_raw;
   logic [SCP_ANG_W-1:0] ang_abs;
   logic mag_ok;
   logic ang_ok;
   logic frq_ok;
   logic byp;

   always_comb begin
      res = '0;
      res.no_selection = ~(v1.valid & v2.valid);
      ang_raw = SCP_ANG_W'(v1.angle - v2.angle);
      ang_abs = ang_raw[SCP_ANG_W-1] ? SCP_ANG_W'(-ang_raw) : ang_raw;
      mag_ok = abs_diff(v1.kv, v2.kv) < cfg.max_magnitude_difference; // R4
      ang_ok = ang_abs < cfg.max_angle_difference; // R5
      frq_ok = abs_diff(v1.frequency, v2.frequency) <
               cfg.max_frequency_difference; // R6
      res.first_is_dead = v1.valid & (v1.pu < cfg.first_dead_threshold); // R9
      res.second_is_dead = v2.valid & (v2.pu < cfg.second_dead_threshold); // R9
      res.first_is_live = v1.valid & (v1.pu > cfg.first_live_threshold); // R10
      res.second_is_live = v2.valid & (v2.pu > cfg.second_live_threshold); // R10
      res.sync_ok = v1.valid & v2.valid & mag_ok & ang_ok & frq_ok; // R2
      case (cfg.dead_live_bypass_select) // R8
         SCP_BYP_NONE: byp = 1'b0;
         SCP_BYP_L1_D2: byp = res.first_is_live & res.second_is_dead;
         SCP_BYP_D1_L2: byp = res.first_is_dead & res.second_is_live;
         SCP_BYP_D1_OR_D2: byp = res.first_is_dead | res.second_is_dead;
         SCP_BYP_D1_XOR_D2: byp = (res.first_is_dead & res.second_is_live) |
                                  (res.second_is_dead & res.first_is_live);
         SCP_BYP_D1_AND_D2: byp = res.first_is_dead & res.second_is_dead;
         default: byp = 1'b0;
      endcase
      res.permit = res.sync_ok | byp; // R7
   end

endmodule : scp_check

// File: scp_top_asserts.sv
// Purpose: port-level checks of the close-permit supervisor
// Assumes: one wait state per bus access
// Notes: status reads stand in for the hidden per-instance state
`timescale 1ns/1ps
module scp_top_asserts
   import scp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic update_strobe,
   input wire scp_source_t [7:0] sources,
   input wire logic [SCP_NUM_INST-1:0] close_permit
);
   // ----------
   // helpers
   // ----------
   logic req, done_rd, st_rd, gap_rd;
   assign req = avs_read | avs_write;
   assign done_rd = avs_read & ~avs_waitrequest;
   // status word: bit7 clear and the status offset
   assign st_rd = done_rd & ~avs_address[7]
      & (avs_address[5:0] == SCP_OFS_STATUS[5:0]);
   assign gap_rd = done_rd & (avs_address[7] | (avs_address[5:2] > 4'h9));
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ----------
   // checks
   // ----------
   chk_wait_first: assert property ($rose(req) |-> avs_waitrequest)
      else $error("new request not held off");
   chk_one_wait: assert property ($rose(req) |=> !avs_waitrequest)
      else $error("request not answered after one wait");
   chk_idle_nowait: assert property (!req |-> !avs_waitrequest)
      else $error("waitrequest high while idle");
   chk_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
      rst |=> (close_permit == 2'b00))
      else $error("permit not cleared by reset");
   chk_hold_nostrobe: assert property (!update_strobe |=>
      $stable(close_permit))
      else $error("permit moved without a strobe");
   chk_gap_zero: assert property (gap_rd |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   chk_status_permit: assert property (st_rd && !$past(update_strobe) |->
      avs_readdata[SCP_ST_PERMIT] == close_permit[avs_address[6]])
      else $error("status permit differs from output");
   chk_sync_permit: assert property (st_rd && avs_readdata[SCP_ST_SYNC]
      |-> avs_readdata[SCP_ST_PERMIT])
      else $error("sync without permit");
   chk_bypass_dead: assert property (st_rd && avs_readdata[SCP_ST_PERMIT]
      && !avs_readdata[SCP_ST_SYNC] |-> avs_readdata[SCP_ST_DEAD1]
      || avs_readdata[SCP_ST_DEAD2])
      else $error("bypass permit with no dead side");
endmodule : scp_top_asserts
bind scp_top scp_top_asserts i_chk (.clk, .rst, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .update_strobe, .sources, .close_permit);

// File: scp_meas_model.sv
// Purpose: upstream measurement side, holds eight source descriptors
// Assumes: loaded one source per cycle by the bench
// Notes: strobe follows fire by one cycle, sources by the same edge
`timescale 1ns/1ps
module scp_meas_model
   import scp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic set_en,
   input wire logic [2:0] set_idx,
   input wire scp_source_t set_val,
   input wire logic fire,
   output scp_source_t [7:0] sources,
   output logic update_strobe
);
   always_ff @(posedge clk) begin
      if (rst) begin
         update_strobe <= 1'b0;
      end else begin
         if (set_en) begin
            sources[set_idx] <= set_val;
         end
         update_strobe <= fire;
      end
   end
endmodule : scp_meas_model

// File: scp_top_tb.sv
// Purpose: self-checking bench for the close-permit supervisor
// Assumes: Avalon master waits on waitrequest, seed 68
// Notes: expectations come from a bench-side reference
`timescale 1ns/1ps
module scp_top_tb
   import scp_pkg::*;
();
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic update_strobe;
   scp_source_t [7:0] sources;
   logic [1:0] close_permit;
   logic set_en = 1'b0;
   logic [2:0] set_idx = 3'h0;
   scp_source_t set_val = '0;
   logic fire = 1'b0;
   logic pm_due = 1'b0;
   logic [31:0] exp_rd[$];
   logic [1:0] exp_pm[$];
   int n_mismatch = 0;
   int checks = 0;
   scp_settings_t cfg[2];
   scp_source_t src_m[8];
   always #12.5 clk = ~clk;
   scp_top i_dut (.clk, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .update_strobe, .sources, .close_permit);
   scp_meas_model i_meas (.clk, .rst, .set_en, .set_idx, .set_val, .fire,
      .sources, .update_strobe);
   // ----------
   // reporting
   // ----------
   task automatic check(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run
   always @(posedge clk) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         check(avs_readdata, exp_rd.pop_front());
      end
      if (pm_due) begin
         check({30'h0, close_permit}, {30'h0, exp_pm.pop_front()});
      end
      pm_due = update_strobe && !rst;
   end
   // ----------
   // bus master
   // ----------
   task automatic xfer(input logic [7:0] a, input logic wr_n,
         input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_read <= ~wr_n;
      avs_write <= wr_n;
      avs_writedata <= d;
      avs_byteenable <= be;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         n_mismatch++;
         complete_run();
      end
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] be = 4'hF);
      xfer(a, 1'b1, d, be);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      xfer(a, 1'b0, 32'h0, 4'hF);
   endtask : rd
   task automatic put_cfg(input int i);
      logic [7:0] b;
      scp_settings_t c;
      b = (i == 1) ? 8'h40 : 8'h00;
      c = cfg[i];
      wr(b + SCP_OFS_SRC_SEL, {25'h0, c.second_voltage_source_select,
         1'b0, c.first_voltage_source_select});
      wr(b + SCP_OFS_MAX_MAG, {16'h0, c.max_magnitude_difference});
      wr(b + SCP_OFS_MAX_ANG, {16'h0, c.max_angle_difference});
      wr(b + SCP_OFS_MAX_FRQ, {16'h0, c.max_frequency_difference});
      wr(b + SCP_OFS_DEAD_SEL, {29'h0, c.dead_live_bypass_select});
      wr(b + SCP_OFS_DEAD1, {16'h0, c.first_dead_threshold});
      wr(b + SCP_OFS_DEAD2, {16'h0, c.second_dead_threshold});
      wr(b + SCP_OFS_LIVE1, {16'h0, c.first_live_threshold});
      wr(b + SCP_OFS_LIVE2, {16'h0, c.second_live_threshold});
   endtask : put_cfg
   // ----------
   // reference
   // ----------
   function automatic logic [15:0] absd(input logic [15:0] x, y);
      return (x > y) ? x - y : y - x;
   endfunction : absd
   function automatic scp_compared_t pick(input scp_source_t s, o);
      scp_compared_t c;
      c = {1'b1, s.phase_a_to_b_voltage, s.phase_a_to_b_pu,
         s.phase_a_to_b_angle, s.frequency};
      if (!s.has_phase) begin
         c = {1'b1, s.aux_voltage, s.aux_pu, s.aux_angle, s.frequency};
      end else if (!o.has_phase && o.aux_is_phase_a_ground) begin
         c = {1'b1, s.phase_a_to_ground_voltage, s.phase_a_to_ground_pu,
            s.phase_a_to_ground_angle, s.frequency};
      end
      return c;
   endfunction : pick
   function automatic logic [31:0] ref_st(input int i);
      scp_settings_t c;
      scp_compared_t a, b;
      scp_source_t y, z;
      logic sy, d1, d2, l1, l2, by;
      c = cfg[i];
      y = src_m[c.first_voltage_source_select];
      z = src_m[c.second_voltage_source_select];
      // a side with no voltage channel leaves nothing to compare
      if (!(y.has_phase | y.has_aux) || !(z.has_phase | z.has_aux)) begin
         return 32'h1 << SCP_ST_NOSEL;
      end
      a = pick(y, z);
      b = pick(z, y);
      sy = absd(a.kv, b.kv) < c.max_magnitude_difference
         && absd(a.angle, b.angle) < c.max_angle_difference
         && absd(a.frequency, b.frequency) < c.max_frequency_difference;
      d1 = a.pu < c.first_dead_threshold;
      d2 = b.pu < c.second_dead_threshold;
      l1 = a.pu > c.first_live_threshold;
      l2 = b.pu > c.second_live_threshold;
      case (c.dead_live_bypass_select)
         SCP_BYP_L1_D2: by = l1 & d2;
         SCP_BYP_D1_L2: by = d1 & l2;
         SCP_BYP_D1_OR_D2: by = d1 | d2;
         SCP_BYP_D1_XOR_D2: by = (d1 & l2) | (l1 & d2);
         SCP_BYP_D1_AND_D2: by = d1 & d2;
         default: by = 1'b0;
      endcase
      return {25'h0, 1'b0, l2, l1, d2, d1, sy, sy | by};
   endfunction : ref_st
   function automatic logic [15:0] rnd(input int lo, hi);
      return 16'($urandom_range(lo, hi));
   endfunction : rnd
   function automatic scp_source_t gen_src();
      int k;
      // k of 3 gives a source with no voltage channel
      k = $urandom_range(0, 3);
      return {k < 2, k == 1 || k == 2, 1'b0, 1'($urandom),
         rnd(100, 140), rnd(100, 140), rnd(100, 140), rnd(0, 40),
         rnd(0, 40), rnd(0, 40), rnd(0, 180), rnd(0, 180), rnd(0, 180),
         rnd(590, 610)};
   endfunction : gen_src
   // ----------
   // sequence
   // ----------
   initial begin
      int i, t;
      logic [31:0] s0, s1;
      scp_settings_t c;
      void'($urandom(68));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 22; i++) begin
         rd(8'(i / 11) * 8'h40 + 8'(i % 11) * 8'h04,
            (i % 11 == 0) ? 32'h0000_0010 : 32'h0);
      end
      rd(8'h84, 32'h0);
      wr(8'h04, 32'hFFFF_ABCD, 4'h1);
      wr(8'h84, 32'h0000_1234);
      wr(8'h24, 32'h0000_007F);
      wr(8'h10, 32'h0000_0007);
      rd(8'h04, 32'h0000_00CD);
      rd(8'h24, 32'h0);
      rd(8'h10, 32'h0);
      for (t = 0; t < 60; t++) begin
         for (i = 0; i < 2; i++) begin
            c = {3'($urandom_range(0, 7)), 3'h0, rnd(0, 40), rnd(0, 180),
               rnd(0, 20), 3'h0, rnd(0, 40), rnd(0, 40), rnd(0, 40),
               rnd(0, 40)};
            c.second_voltage_source_select = c.first_voltage_source_select
               + 3'($urandom_range(1, 7));
            c.dead_live_bypass_select = scp_bypass_t'((t + i) % 6);
            cfg[i] = c;
            put_cfg(i);
         end
         for (i = 0; i < 8; i++) begin
            @(posedge clk);
            src_m[i] = gen_src();
            set_en <= 1'b1;
            set_idx <= 3'(i);
            set_val <= src_m[i];
         end
         @(posedge clk);
         set_en <= 1'b0;
         fire <= 1'b1;
         s0 = ref_st(0);
         s1 = ref_st(1);
         repeat (1 + t % 2) begin
            exp_pm.push_back({s1[0], s0[0]});
            @(posedge clk);
         end
         fire <= 1'b0;
         rd(8'h24, s0);
         rd(8'h64, s1);
         rd(8'h24, s0);
      end
      repeat (3) @(posedge clk);
      complete_run();
   end
endmodule : scp_top_tb
